// ==== core/aerus_top.sv ====
// error reporting capability header and uncorrectable status register
// assumes reset inputs come from the reset controller on core_clk_i,
// and the mask word from the mask register kept elsewhere
`timescale 1ns/100ps
`include "aerus_defines.svh"
module aerus_top (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic global_reset_in_b_i,
  input wire logic fund_reset_b_i,
  input wire logic hot_reset_i,
  input wire aerus_pkg::aerus_cfg_req_s cfg_req_i,
  output aerus_pkg::aerus_cfg_rsp_s cfg_rsp_o,
  input wire aerus_pkg::aerus_event_s err_event_i,
  input wire logic [31:0] err_mask_i,
  output logic [31:0] uncorr_flags_o
);

  aerus_pkg::aerus_state_s st;
  aerus_pkg::aerus_state_s next_st;
  logic [31:0] ev_vec;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] be_mask;
  logic [31:0] rd_word;
  logic [31:0] cap_word;
  logic stat_rst;
  logic any_rst;
  logic sticky_rst;
  logic hit_cap;
  logic hit_stat;

  // place each event pulse on its status bit position
  always_comb begin
    ev_vec = 32'h00000000;
    ev_vec[`AERUS_UR_BIT] = err_event_i.unsupported_request_flag;
    ev_vec[`AERUS_ECRC_BIT] = err_event_i.end_to_end_crc_fail_flag;
    ev_vec[`AERUS_MAL_BIT] = err_event_i.malformed_packet_flag;
    ev_vec[`AERUS_OVR_BIT] = err_event_i.credit_overrun_flag;
    ev_vec[`AERUS_STRAY_BIT] = err_event_i.stray_completion_flag;
    ev_vec[`AERUS_CA_BIT] = err_event_i.completer_abort_flag;
    ev_vec[`AERUS_CTO_BIT] = err_event_i.completion_timeout_flag;
    ev_vec[`AERUS_FC_BIT] = err_event_i.flow_credit_protocol_flag;
    ev_vec[`AERUS_PSN_BIT] = err_event_i.poisoned_packet_flag;
    ev_vec[`AERUS_DLL_BIT] = err_event_i.link_protocol_flag;
  end

  // reset classes; hot reset is left out of the status class
  // status reset class
  assign stat_rst = !rst_b_i || !global_reset_in_b_i || !fund_reset_b_i;
  assign any_rst = stat_rst || hot_reset_i;
  // sticky class, only power-on and global reset
  assign sticky_rst = !rst_b_i || !global_reset_in_b_i;

  // address decode on the dword; both header halves share one dword
  assign hit_cap = cfg_req_i.addr[11:2] == 10'(`AERUS_ID_OFS >> 2);
  assign hit_stat = cfg_req_i.addr[11:2] == 10'(`AERUS_STAT_OFS >> 2);

  // identifier low half, pointer upper bits
  // version in low four bits of the upper half
  assign cap_word = {`AERUS_NEXT_PTR, `AERUS_CAP_VER, `AERUS_CAP_ID};

  // expand byte enables to bit lanes for the clear mask
  always_comb begin
    be_mask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}},
               {8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};
  end

  // set and clear terms of the status word
  always_comb begin
    set_vec = ev_vec & ~err_mask_i & `AERUS_STAT_LIVE;
    clr_vec = 32'h00000000;
    // reserved and read-only bits take no write
    if (cfg_req_i.req && cfg_req_i.we && hit_stat) begin
      clr_vec = cfg_req_i.wdata & be_mask & `AERUS_STAT_LIVE;
    end
  end

  // read mux; unmapped dwords read zero and writes there are dropped
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_cap) begin
      rd_word = cap_word;
    end else if (hit_stat) begin
      rd_word = st.flags & `AERUS_STAT_LIVE;
    end
  end

  // next state; the status word and the answer follow different resets
  always_comb begin
    next_st = st;
    next_st.flags = ((st.flags & ~clr_vec) | set_vec) & `AERUS_STAT_LIVE;
    next_st.rsp.ack = cfg_req_i.req;
    next_st.rsp.rdata = 32'h00000000;
    if (cfg_req_i.req && !cfg_req_i.we) begin
      next_st.rsp.rdata = rd_word;
    end
    // answer path clears on any reset
    if (any_rst) begin
      next_st.rsp = '0;
    end
    // status clears, but not on hot reset alone
    if (stat_rst) begin
      next_st.flags = `AERUS_STAT_RST;
    end
  end

  // single state register; all resets are synchronous
  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // outputs straight from the state flops
  assign cfg_rsp_o = st.rsp;
  assign uncorr_flags_o = st.flags;

  // a header dword read made outside a reset gives the capability identifier in its low half
  a_cap_read_value: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && !cfg_req_i.we && hit_cap && !any_rst)
    |=> (cfg_rsp_o.ack && cfg_rsp_o.rdata[15:0] == 16'h0001))
    else $error("capability identifier read wrong");

  // pointer and version in the upper half of the header dword
  a_next_ver_value: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && !cfg_req_i.we && hit_cap && !any_rst)
    |=> (cfg_rsp_o.rdata[31:16] == 16'h0001))
    else $error("next pointer or version read wrong");

  // a write to the header changes what the next read returns not at all
  a_cap_write_ignored: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && cfg_req_i.we && hit_cap && !any_rst)
    ##1 (cfg_req_i.req && !cfg_req_i.we && hit_cap && !any_rst)
    |=> (cfg_rsp_o.rdata == 32'h00010001))
    else $error("capability header took a write");

  // every request made outside a reset is answered exactly one cycle later
  a_answer_latency: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && !any_rst) |=> cfg_rsp_o.ack)
    else $error("configuration request not answered");

  // unmasked events reach their flags on the next edge
  a_event_sets_flag: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !stat_rst |=> ((($past(ev_vec) & ~$past(err_mask_i)
      & `AERUS_STAT_LIVE) & ~uncorr_flags_o) == 32'h00000000))
    else $error("unmasked error event lost");

  // a flag rises only from an unmasked event
  a_mask_blocks_set: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    1'b1 |=> ((uncorr_flags_o & ~$past(uncorr_flags_o)
      & ~$past(set_vec)) == 32'h00000000))
    else $error("flag set without unmasked event");

  // zero bits of a status write leave flags alone
  a_zero_write_keeps: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && cfg_req_i.we && hit_stat && !stat_rst)
    |=> (($past(uncorr_flags_o) & ~$past(cfg_req_i.wdata & be_mask)
      & ~uncorr_flags_o) == 32'h00000000))
    else $error("flag cleared by a zero write");

  // full write of ones with no event empties the status word
  a_ones_write_clears: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && cfg_req_i.we && hit_stat && cfg_req_i.be == 4'hF
      && cfg_req_i.wdata == 32'hFFFFFFFF && set_vec == 32'h00000000)
    |=> (uncorr_flags_o == 32'h00000000))
    else $error("write of ones did not clear flags");

  // a clear that meets an event leaves that flag set
  a_set_beats_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (|(set_vec & clr_vec) && !stat_rst)
    |=> ((($past(set_vec & clr_vec)) & ~uncorr_flags_o) == 32'h00000000))
    else $error("event lost against a clear");

  // unsupported and reserved positions never read one
  a_reserved_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (uncorr_flags_o & ~`AERUS_STAT_LIVE) == 32'h00000000)
    else $error("reserved status bit set");

  // access control and surprise down flags stay clear even if pulsed
  a_unsupported_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !uncorr_flags_o[`AERUS_ACS_BIT] && !uncorr_flags_o[`AERUS_SD_BIT])
    else $error("unsupported error flag set");

  // hot reset alone keeps every flag that no write in the same cycle clears, and drops the answer
  a_hot_keeps_flags: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (hot_reset_i && !stat_rst)
    |=> ((($past(uncorr_flags_o) & ~$past(clr_vec)) & ~uncorr_flags_o)
      == 32'h00000000 && !cfg_rsp_o.ack))
    else $error("hot reset disturbed flags or answer");

  // fundamental or global reset empties the status word
  a_fund_clears: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (!fund_reset_b_i || !global_reset_in_b_i)
    |=> (uncorr_flags_o == 32'h00000000 && !cfg_rsp_o.ack))
    else $error("status not cleared by reset");

  // a reset of the sticky class also empties the status word
  a_sticky_subset: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    sticky_rst |=> (uncorr_flags_o == 32'h00000000 && !cfg_rsp_o.ack))
    else $error("sticky class reset left status set");

  // a read of the status dword returns what the flags held
  a_status_readback: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && !cfg_req_i.we && hit_stat && !any_rst)
    |=> (cfg_rsp_o.rdata == ($past(uncorr_flags_o) & `AERUS_STAT_LIVE)))
    else $error("status read does not match flags");

  // unmapped reads return zero
  a_unmapped_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cfg_req_i.req && !hit_cap && !hit_stat && !any_rst)
    |=> (cfg_rsp_o.rdata == 32'h00000000))
    else $error("unmapped address returned data");

endmodule

// ==== core/aerus_defines.svh ====
// constants of the error reporting capability header and status word
// assumes byte addresses of the extended configuration space
`ifndef AERUS_DEFINES_SVH
`define AERUS_DEFINES_SVH
`define AERUS_ID_OFS 12'h100
`define AERUS_NEXT_OFS 12'h102
`define AERUS_STAT_OFS 12'h104
`define AERUS_CAP_ID 16'h0001
`define AERUS_NEXT_PTR 12'h000
`define AERUS_CAP_VER 4'h1
`define AERUS_STAT_RST 32'h00000000
`define AERUS_STAT_LIVE 32'h001FF010
`define AERUS_UR_BIT 20
`define AERUS_ECRC_BIT 19
`define AERUS_MAL_BIT 18
`define AERUS_OVR_BIT 17
`define AERUS_STRAY_BIT 16
`define AERUS_CA_BIT 15
`define AERUS_CTO_BIT 14
`define AERUS_FC_BIT 13
`define AERUS_PSN_BIT 12
`define AERUS_DLL_BIT 4
`define AERUS_ACS_BIT 21
`define AERUS_SD_BIT 5
`endif

// ==== core/aerus_pkg.sv ====
// types shared by the capability block and its surroundings
// assumes the constants header is compiled alongside
package aerus_pkg;
  // one pulse per detected error, from the link and transaction layers
  typedef struct packed {
    logic unsupported_request_flag;
    logic end_to_end_crc_fail_flag;
    logic malformed_packet_flag;
    logic credit_overrun_flag;
    logic stray_completion_flag;
    logic completer_abort_flag;
    logic completion_timeout_flag;
    logic flow_credit_protocol_flag;
    logic poisoned_packet_flag;
    logic link_protocol_flag;
  } aerus_event_s;
  // configuration access request, byte address and byte enables
  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } aerus_cfg_req_s;
  // configuration answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } aerus_cfg_rsp_s;
  // whole state of the block
  typedef struct packed {
    logic [31:0] flags;
    aerus_cfg_rsp_s rsp;
  } aerus_state_s;
endpackage

// ==== bench/aerus_host_model.sv ====
// upstream configuration requester standing in for the root complex
// assumes it shares core_clk_i with the block and waits on its ack
`timescale 1ns/100ps
module aerus_host_model (
  input wire logic core_clk_i,
  input wire aerus_pkg::aerus_cfg_rsp_s cfg_rsp_i,
  output aerus_pkg::aerus_cfg_req_s cfg_req_o
);
  initial cfg_req_o = '0;
  // one access: drive after an edge, release at the taking edge, then
  // scramble the idle fields so a stale address is never relied upon
  // clear by ones
  task automatic xfer(input int gap, input logic we,
                      input logic [11:0] addr, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic ok);
    int n;
    n = 0;
    rd = 32'h00000000;
    ok = 1'b0;
    repeat (gap) @(posedge core_clk_i);
    @(posedge core_clk_i);
    cfg_req_o <= '{req: 1'b1, we: we, addr: addr, be: be, wdata: wd};
    @(posedge core_clk_i);
    cfg_req_o <= '{req: 1'b0, we: ~we, addr: ~addr, be: ~be, wdata: ~wd};
    // bounded wait; answer taken at the edge after the taking edge
    while (ok !== 1'b1 && n < 4) begin
      @(posedge core_clk_i);
      ok = cfg_rsp_i.ack;
      rd = cfg_rsp_i.rdata;
      n++;
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the error capability header and status word
// assumes the requester model drives all configuration accesses
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic global_reset_in_b = 1'b1;
  logic frst_b = 1'b1;
  logic hot = 1'b0;
  aerus_pkg::aerus_cfg_req_s req;
  aerus_pkg::aerus_cfg_rsp_s rsp;
  aerus_pkg::aerus_event_s ev = '0;
  logic [31:0] mask = 32'h0;
  logic [31:0] flags;
  logic [31:0] exp;
  logic [31:0] d;
  int err_count = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  aerus_top u_dut (.core_clk_i(clk), .rst_b_i(rst_b),
    .global_reset_in_b_i(global_reset_in_b), .fund_reset_b_i(frst_b),
    .hot_reset_i(hot), .cfg_req_i(req), .cfg_rsp_o(rsp),
    .err_event_i(ev), .err_mask_i(mask), .uncorr_flags_o(flags));

  aerus_host_model u_host (.core_clk_i(clk), .cfg_rsp_i(rsp),
    .cfg_req_o(req));

  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, want, seen);
    end
  endtask

  // every access must be answered, reads pause a cycle first
  task automatic acc(input logic we, input logic [11:0] a,
                     input logic [3:0] be, input logic [31:0] wd);
    logic ok;
    u_host.xfer(we ? 0 : 1, we, a, be, wd, d, ok);
    check("ack", {31'h0, ok}, 32'h1);
  endtask

  // event vector is msb first, bits 20 down to 12, then bit 4
  function automatic logic [31:0] fl(input logic [9:0] v);
    return {11'h0, v[9:1], 7'h0, v[0], 4'h0};
  endfunction

  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    ev <= aerus_pkg::aerus_event_s'(v);
    @(posedge clk);
    ev <= '0;
    #1;
  endtask

  // hold one reset class across two edges, then release all
  task automatic do_rst(input int k);
    @(posedge clk);
    case (k)
      0: hot <= 1'b1;
      1: frst_b <= 1'b0;
      2: global_reset_in_b <= 1'b0;
      default: rst_b <= 1'b0;
    endcase
    repeat (2) @(posedge clk);
    hot <= 1'b0;
    frst_b <= 1'b1;
    global_reset_in_b <= 1'b1;
    rst_b <= 1'b1;
    #1;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    acc(1'b0, 12'h100, 4'hF, 32'h0);
    check("header", d, 32'h00010001);
    acc(1'b1, 12'h100, 4'hF, 32'hFFFFFFFF);
    acc(1'b0, 12'h100, 4'hF, 32'h0);
    check("header wr", d, 32'h00010001);
    acc(1'b0, 12'h104, 4'hF, 32'h0);
    check("status rst", d, 32'h00000000);
    acc(1'b0, 12'h200, 4'hF, 32'h0);
    check("unmapped", d, 32'h00000000);
    exp = 32'h0;
    for (int i = 0; i < 10; i++) begin
      pulse(10'h200 >> i);
      exp |= fl(10'h200 >> i);
      check("flags", flags, exp);
    end
    acc(1'b0, 12'h104, 4'hF, 32'h0);
    check("status", d, exp);
    // masked events and unsupported bits must not set anything
    acc(1'b1, 12'h104, 4'hF, 32'hFFFFFFFF);
    @(posedge clk);
    mask <= 32'hFFFFFFFF;
    pulse(10'h3FF);
    check("masked", flags, 32'h0);
    @(posedge clk);
    mask <= 32'h00100010;
    pulse(10'h3FF);
    check("part mask", flags, 32'h000FF000);
    @(posedge clk);
    mask <= 32'h0;
    pulse(10'h3FF);
    exp = 32'h001FF010;
    acc(1'b1, 12'h104, 4'h4, 32'hFFFFFFFF);
    exp &= ~32'h00FF0000;
    acc(1'b1, 12'h104, 4'hF, 32'h0000F000);
    exp &= ~32'h0000F000;
    acc(1'b1, 12'h104, 4'hF, 32'h0);
    acc(1'b0, 12'h104, 4'hF, 32'h0);
    check("w1c", d, exp);
    // clear and event on the same edge, the event must survive
    fork
      acc(1'b1, 12'h104, 4'hF, 32'hFFFFFFFF);
      pulse(10'h200);
    join
    check("set wins", flags, 32'h00100000);
    for (int k = 0; k < 4; k++) begin
      pulse(10'h3FF);
      do_rst(k);
      exp = (k == 0) ? 32'h001FF010 : 32'h0;
      check("reset", flags, exp);
    end
    acc(1'b0, 12'h100, 4'hF, 32'h0);
    check("header post", d, 32'h00010001);
    conclude();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #40000;
    err_count++;
    conclude();
  end
endmodule
